/* File: hoc_cfg.svh */
// offsets, field positions, reset values and timing constants of the holdover controller
`ifndef HOC_CFG_SVH
`define HOC_CFG_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define HOC_ADDR_HOLD_STAT   16'h000E
`define HOC_ADDR_IN_SELECT   16'h052A
`define HOC_ADDR_EXIT_CTRL   16'h052C
`define HOC_ADDR_HIST_LEN    16'h052E
`define HOC_ADDR_HIST_DLY    16'h052F
`define HOC_ADDR_FORCE       16'h0535
`define HOC_ADDR_POLICY      16'h0536
`define HOC_ADDR_PRIO_LO     16'h0538
`define HOC_ADDR_PRIO_HI     16'h0539
`define HOC_ADDR_HIST_STAT   16'h053F
`define HOC_ADDR_EXIT_BW_LO  16'h059B
`define HOC_ADDR_STEP_SIZE   16'h05A6

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HOC_BIT_HOLD_STAT    5
`define HOC_BIT_HIST_GOOD    1
`define HOC_BIT_RAMP_BYP     3
`define HOC_BIT_BW_HI        4
`define HOC_BIT_BW_LO        6
`define HOC_LSB_SPACING      5
`define HOC_LSB_CHOICE       1
`define HOC_LSB_PRIO_ODD     4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HOC_RST_HIST_LEN     5'h0A
`define HOC_RST_HIST_DLY     5'h08
`define HOC_RST_BW_HI        1'h0
`define HOC_RST_BW_LO        1'h1
`define HOC_RST_SPACING      3'h0
`define HOC_RST_STEP_SIZE    3'h0
`define HOC_RST_POLICY       2'h0

// ----------------------------------------------------------------
// codes and timing
// ----------------------------------------------------------------
`define HOC_POLICY_MANUAL    2'h0
`define HOC_POLICY_NONREV    2'h1
`define HOC_POLICY_REVERT    2'h2
`define HOC_BW_FASTLOCK      2'h0
`define HOC_BW_HOLD_EXIT     2'h1
`define HOC_BW_NORMAL        2'h2
`define HOC_PRIO_BEST        3'h1
`define HOC_PRIO_WORST       3'h4
`define HOC_INPUT_LIMIT      3'h4
`define HOC_CLK_PERIOD_NS    10
`define HOC_HIST_UNIT_NS     100
`define HOC_HIST_UNIT_SPLIT  3
`define HOC_WIN_SHIFT        3
`define HOC_DLY_SHIFT        1

`endif

/* File: hoc_pkg.sv */
// types shared by the holdover and input select controller
package hoc_pkg;

	// loop operating modes
	typedef enum logic [1:0] {
		HOC_FREERUN,
		HOC_NORMAL,
		HOC_HOLDOVER,
		HOC_EXIT
	} hoc_state_type;

	// index of one of the four clock inputs
	typedef logic [1:0] hoc_input_type;

	// priority code of one clock input
	typedef logic [2:0] hoc_prio_type;

endpackage

/* File: hoc_hist_timer.sv */
// history qualification timer: window length plus ignore delay
`timescale 1ns/1ns
`include "hoc_cfg.svh"

module hoc_hist_timer (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       accumulate,
	input  wire logic [4:0] window_code,
	input  wire logic [4:0] delay_code,
	// status
	output logic            history_good
);

	localparam logic [7:0] FRAC_INC = 8'(`HOC_CLK_PERIOD_NS * `HOC_HIST_UNIT_SPLIT);
	localparam logic [7:0] FRAC_MOD = 8'(`HOC_HIST_UNIT_NS);

	logic [7:0]  frac_ff;
	logic [7:0]  frac_sum;
	logic        tick;
	logic [35:0] win_thirds;
	logic [35:0] dly_thirds;
	logic [35:0] target;
	logic [35:0] count_ff;

	// time base in thirds of 100 ns, exact at clock periods up to 33 ns
	assign frac_sum = frac_ff + FRAC_INC;
	assign tick     = (frac_sum >= FRAC_MOD);

	// window and delay both measured in thirds of 100 ns
	assign win_thirds = ((36'h1 << window_code) - 36'h1) << `HOC_WIN_SHIFT;
	assign dly_thirds = (36'h1 << delay_code) << `HOC_DLY_SHIFT;
	assign target     = win_thirds + dly_thirds;

	// fractional accumulator, runs only while history is gathered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frac_ff <= 8'h00;
		end else if (accumulate) begin
			frac_ff <= tick ? frac_sum - FRAC_MOD : frac_sum;
		end
	end

	// elapsed history, suspended while no input is followed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_ff <= 36'h0;
		end else if (accumulate && tick && count_ff < target) begin
			count_ff <= count_ff + 36'h1;
		end
	end

	// average is usable once window and delay have both elapsed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			history_good <= 1'b0;
		end else begin
			history_good <= (count_ff >= target);
		end
	end

endmodule

/* File: hoc_ramp_pacer.sv */
// frequency ramp step pacer for holdover exit
`timescale 1ns/1ns

module hoc_ramp_pacer #(
	parameter int BASE_CYCLES = 16
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       run,
	input  wire logic [2:0] spacing,
	// step strobe
	output logic            step
);

	logic [23:0] count_ff;
	logic [23:0] period;

	// interval doubles with each spacing code
	assign period = 24'(BASE_CYCLES) << spacing;

	// interval counter, restarts whenever the ramp is idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_ff <= 24'h0;
		end else if (!run || count_ff >= period - 24'h1) begin
			count_ff <= 24'h0;
		end else begin
			count_ff <= count_ff + 24'h1;
		end
	end

	// one pulse per elapsed interval
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step <= 1'b0;
		end else begin
			step <= run && (count_ff >= period - 24'h1);
		end
	end

endmodule

/* File: hoc_ctrl.sv */
// holdover and input select controller top
`timescale 1ns/1ns
`include "hoc_cfg.svh"

module hoc_ctrl
	import hoc_pkg::*;
#(
	parameter int RAMP_BASE_CYCLES = 16
) (
	// clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	// register port
	input  wire logic [15:0] REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	// select pins and clock monitors
	input  wire logic [1:0]  SEL_PINS,
	input  wire logic [3:0]  CLK_VALID,
	// loop feedback
	input  wire logic        RAMP_DONE,
	input  wire logic        LOCK_DONE,
	// input choice
	output logic      [1:0]  ACTIVE_INPUT,
	// loop mode
	output logic             HOLD_STATUS,
	output logic             HOLDOVER_MODE,
	output logic             FREERUN_MODE,
	output logic             EXIT_ACTIVE,
	output logic      [1:0]  LOOP_BW_SEL,
	// history averaging
	output logic             HIST_ACCUM,
	output logic             HISTORY_GOOD,
	output logic      [4:0]  HIST_LEN_CODE,
	output logic      [4:0]  HIST_DELAY_CODE,
	// frequency ramp
	output logic             RAMP_ACTIVE,
	output logic             RAMP_STEP,
	output logic      [2:0]  RAMP_STEP_SIZE
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic          manual_select_source_ff;
	logic [2:0]    manual_input_choice_ff;
	logic          exit_ramp_bypass_ff;
	logic          exit_bandwidth_select_hi_ff;
	logic          exit_bandwidth_select_lo_ff;
	logic [2:0]    ramp_step_spacing_ff;
	logic [4:0]    history_window_length_ff;
	logic [4:0]    history_ignore_delay_ff;
	logic          forced_holdover_ff;
	logic [1:0]    input_switching_policy_ff;
	hoc_prio_type  prio_ff [4];
	logic [1:0]    sel_pins_meta_ff;
	logic [1:0]    sel_pins_ff;
	hoc_state_type state_ff;
	hoc_state_type nxt_state;
	hoc_input_type active_ff;
	hoc_input_type nxt_active;
	logic [3:0]    eligible;
	logic          best_found;
	hoc_input_type best_idx;
	hoc_prio_type  best_prio;
	hoc_input_type manual_cand;
	logic          manual_ok;
	logic          sel_valid;
	logic          lost;
	logic          exit_done;
	logic          ramp_exit_ff;
	logic          history_average_good;
	logic [1:0]    exit_bw_code;
	logic          wr_hit;

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------

	// write strobe qualifies every decoded store
	assign wr_hit = REG_WR;

	// input select and switching policy registers
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			manual_select_source_ff   <= 1'b0;
			manual_input_choice_ff    <= 3'h0;
			input_switching_policy_ff <= `HOC_RST_POLICY;
		end else if (wr_hit) begin
			if (REG_ADDR == `HOC_ADDR_IN_SELECT) begin
				manual_select_source_ff <= REG_WDATA[0];
				manual_input_choice_ff  <= REG_WDATA[`HOC_LSB_CHOICE +: 3];
			end
			if (REG_ADDR == `HOC_ADDR_POLICY) begin
				input_switching_policy_ff <= REG_WDATA[1:0];
			end
		end
	end

	// per-input priorities for automatic switching
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			prio_ff[0] <= 3'h1;
			prio_ff[1] <= 3'h2;
			prio_ff[2] <= 3'h3;
			prio_ff[3] <= 3'h4;
		end else if (wr_hit) begin
			if (REG_ADDR == `HOC_ADDR_PRIO_LO) begin
				prio_ff[0] <= REG_WDATA[2:0];
				prio_ff[1] <= REG_WDATA[`HOC_LSB_PRIO_ODD +: 3];
			end
			if (REG_ADDR == `HOC_ADDR_PRIO_HI) begin
				prio_ff[2] <= REG_WDATA[2:0];
				prio_ff[3] <= REG_WDATA[`HOC_LSB_PRIO_ODD +: 3];
			end
		end
	end

	// holdover exit and ramp registers
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			exit_ramp_bypass_ff         <= 1'b0;
			exit_bandwidth_select_hi_ff <= `HOC_RST_BW_HI;
			exit_bandwidth_select_lo_ff <= `HOC_RST_BW_LO;
			ramp_step_spacing_ff        <= `HOC_RST_SPACING;
			RAMP_STEP_SIZE              <= `HOC_RST_STEP_SIZE;
		end else if (wr_hit) begin
			if (REG_ADDR == `HOC_ADDR_EXIT_CTRL) begin
				exit_ramp_bypass_ff         <= REG_WDATA[`HOC_BIT_RAMP_BYP];
				exit_bandwidth_select_hi_ff <= REG_WDATA[`HOC_BIT_BW_HI];
				ramp_step_spacing_ff        <= REG_WDATA[`HOC_LSB_SPACING +: 3];
			end
			if (REG_ADDR == `HOC_ADDR_EXIT_BW_LO) begin
				exit_bandwidth_select_lo_ff <= REG_WDATA[`HOC_BIT_BW_LO];
			end
			if (REG_ADDR == `HOC_ADDR_STEP_SIZE) begin
				RAMP_STEP_SIZE <= REG_WDATA[2:0];
			end
		end
	end

	// history timing and forced holdover registers
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			history_window_length_ff <= `HOC_RST_HIST_LEN;
			history_ignore_delay_ff  <= `HOC_RST_HIST_DLY;
			forced_holdover_ff       <= 1'b0;
		end else if (wr_hit) begin
			if (REG_ADDR == `HOC_ADDR_HIST_LEN) begin
				history_window_length_ff <= REG_WDATA[4:0];
			end
			if (REG_ADDR == `HOC_ADDR_HIST_DLY) begin
				history_ignore_delay_ff <= REG_WDATA[4:0];
			end
			if (REG_ADDR == `HOC_ADDR_FORCE) begin
				forced_holdover_ff <= REG_WDATA[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------

	// read data registered one cycle after the strobe, held until next read
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			REG_RDATA <= 8'h00;
			unique case (REG_ADDR)
				`HOC_ADDR_HOLD_STAT:  REG_RDATA[`HOC_BIT_HOLD_STAT] <= HOLD_STATUS;
				`HOC_ADDR_IN_SELECT:  REG_RDATA[3:0] <= {manual_input_choice_ff,
					manual_select_source_ff};
				`HOC_ADDR_EXIT_CTRL:  REG_RDATA[7:3] <= {ramp_step_spacing_ff,
					exit_bandwidth_select_hi_ff, exit_ramp_bypass_ff};
				`HOC_ADDR_HIST_LEN:   REG_RDATA[4:0] <= history_window_length_ff;
				`HOC_ADDR_HIST_DLY:   REG_RDATA[4:0] <= history_ignore_delay_ff;
				`HOC_ADDR_FORCE:      REG_RDATA[0] <= forced_holdover_ff;
				`HOC_ADDR_POLICY:     REG_RDATA[1:0] <= input_switching_policy_ff;
				`HOC_ADDR_PRIO_LO:    REG_RDATA <= {1'b0, prio_ff[1], 1'b0, prio_ff[0]};
				`HOC_ADDR_PRIO_HI:    REG_RDATA <= {1'b0, prio_ff[3], 1'b0, prio_ff[2]};
				`HOC_ADDR_HIST_STAT:  REG_RDATA[`HOC_BIT_HIST_GOOD] <= history_average_good;
				`HOC_ADDR_EXIT_BW_LO: REG_RDATA[`HOC_BIT_BW_LO] <= exit_bandwidth_select_lo_ff;
				`HOC_ADDR_STEP_SIZE:  REG_RDATA[2:0] <= RAMP_STEP_SIZE;
				default:              REG_RDATA <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// input selection
	// ----------------------------------------------------------------

	// select pins come from the board, two stages before use
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			sel_pins_meta_ff <= 2'h0;
			sel_pins_ff      <= 2'h0;
		end else begin
			sel_pins_meta_ff <= SEL_PINS;
			sel_pins_ff      <= sel_pins_meta_ff;
		end
	end

	// manual candidate from pins or register field
	always_comb begin
		manual_cand = manual_select_source_ff ? manual_input_choice_ff[1:0] : sel_pins_ff;
		manual_ok   = !manual_select_source_ff ||
			(manual_input_choice_ff < `HOC_INPUT_LIMIT);
	end

	// best valid input; priority 1 wins, 0 and 5-7 never chosen
	always_comb begin
		best_found = 1'b0;
		best_idx   = 2'h0;
		best_prio  = 3'h7;
		for (int i = 0; i < 4; i++) begin
			eligible[i] = CLK_VALID[i] && prio_ff[i] >= `HOC_PRIO_BEST &&
				prio_ff[i] <= `HOC_PRIO_WORST;
			if (eligible[i] && prio_ff[i] < best_prio) begin
				best_found = 1'b1;
				best_idx   = 2'(i);
				best_prio  = prio_ff[i];
			end
		end
	end

	// next active input per switching policy
	always_comb begin
		nxt_active = active_ff;
		unique case (input_switching_policy_ff)
			`HOC_POLICY_MANUAL: begin
				if (manual_ok) begin
					nxt_active = manual_cand;
				end
			end
			`HOC_POLICY_NONREV: begin
				if (!eligible[active_ff] && best_found) begin
					nxt_active = best_idx;
				end
			end
			`HOC_POLICY_REVERT: begin
				if (best_found) begin
					nxt_active = best_idx;
				end
			end
			default: nxt_active = active_ff;
		endcase
	end

	// followed input is usable only with a valid clock
	always_comb begin
		if (input_switching_policy_ff == `HOC_POLICY_NONREV ||
			input_switching_policy_ff == `HOC_POLICY_REVERT) begin
			sel_valid = eligible[active_ff];
		end else begin
			sel_valid = CLK_VALID[active_ff];
		end
	end

	// active input register
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			active_ff    <= 2'h0;
			ACTIVE_INPUT <= 2'h0;
		end else begin
			active_ff    <= nxt_active;
			ACTIVE_INPUT <= nxt_active;
		end
	end

	// ----------------------------------------------------------------
	// loop mode
	// ----------------------------------------------------------------

	// loss of reference: forced hold, no valid clock, or priority 0 or 5-7 under an automatic policy
	assign lost      = forced_holdover_ff || !sel_valid;
	assign exit_done = ramp_exit_ff ? RAMP_DONE : LOCK_DONE;

	// mode transitions
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			HOC_NORMAL: begin
				if (lost) begin
					nxt_state = history_average_good ? HOC_HOLDOVER : HOC_FREERUN;
				end
			end
			HOC_FREERUN: begin
				if (!lost) begin
					nxt_state = HOC_NORMAL;
				end
			end
			HOC_HOLDOVER: begin
				if (!lost) begin
					nxt_state = HOC_EXIT;
				end
			end
			HOC_EXIT: begin
				if (lost) begin
					nxt_state = HOC_HOLDOVER;
				end else if (exit_done) begin
					nxt_state = HOC_NORMAL;
				end
			end
		endcase
	end

	// exit method latched as holdover ends so later writes cannot glitch it
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ramp_exit_ff <= 1'b1;
		end else if (state_ff == HOC_HOLDOVER && nxt_state == HOC_EXIT) begin
			ramp_exit_ff <= !exit_ramp_bypass_ff;
		end
	end

	// exit bandwidth from the two split select bits
	always_comb begin
		unique case ({exit_bandwidth_select_hi_ff, exit_bandwidth_select_lo_ff})
			2'h0:    exit_bw_code = `HOC_BW_FASTLOCK;
			2'h1:    exit_bw_code = `HOC_BW_HOLD_EXIT;
			default: exit_bw_code = `HOC_BW_NORMAL;
		endcase
	end

	// state and registered mode outputs
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_ff      <= HOC_FREERUN;
			HOLD_STATUS   <= 1'b1;
			HOLDOVER_MODE <= 1'b0;
			FREERUN_MODE  <= 1'b1;
			EXIT_ACTIVE   <= 1'b0;
			HIST_ACCUM    <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			HOLD_STATUS   <= nxt_state == HOC_HOLDOVER || nxt_state == HOC_FREERUN;
			HOLDOVER_MODE <= nxt_state == HOC_HOLDOVER;
			FREERUN_MODE  <= nxt_state == HOC_FREERUN;
			EXIT_ACTIVE   <= nxt_state == HOC_EXIT;
			HIST_ACCUM    <= nxt_state == HOC_NORMAL;
		end
	end

	// loop bandwidth and ramp enable seen by the loop filter
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			LOOP_BW_SEL <= `HOC_BW_NORMAL;
			RAMP_ACTIVE <= 1'b0;
		end else begin
			LOOP_BW_SEL <= (state_ff == HOC_EXIT && !ramp_exit_ff) ?
				exit_bw_code : `HOC_BW_NORMAL;
			RAMP_ACTIVE <= state_ff == HOC_EXIT && ramp_exit_ff;
		end
	end

	// history code outputs for the averager
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			HIST_LEN_CODE   <= `HOC_RST_HIST_LEN;
			HIST_DELAY_CODE <= `HOC_RST_HIST_DLY;
			HISTORY_GOOD    <= 1'b0;
		end else begin
			HIST_LEN_CODE   <= history_window_length_ff;
			HIST_DELAY_CODE <= history_ignore_delay_ff;
			HISTORY_GOOD    <= history_average_good;
		end
	end

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------

	// history qualification, runs only in normal lock
	hoc_hist_timer u_hist (
		.clk          (CLK_SYS),
		.rst_n        (RST_N),
		.accumulate   (state_ff == HOC_NORMAL),
		.window_code  (history_window_length_ff),
		.delay_code   (history_ignore_delay_ff),
		.history_good (history_average_good)
	);

	// ramp step pacing during a ramped exit
	hoc_ramp_pacer #(
		.BASE_CYCLES (RAMP_BASE_CYCLES)
	) u_pacer (
		.clk     (CLK_SYS),
		.rst_n   (RST_N),
		.run     (state_ff == HOC_EXIT && ramp_exit_ff),
		.spacing (ramp_step_spacing_ff),
		.step    (RAMP_STEP)
	);

endmodule

/* File: hoc_ctrl_assertions.sv */
// port checker for the holdover controller
`timescale 1ns/1ns

module hoc_ctrl_assertions #(
	parameter int RAMP_BASE_CYCLES = 16
) (
	// clock, reset, register writes and ramp done
	input wire logic        CLK_SYS,
	input wire logic        RST_N,
	input wire logic [15:0] REG_ADDR,
	input wire logic [7:0]  REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        RAMP_DONE,
	// loop mode, history and ramp
	input wire logic        HOLD_STATUS,
	input wire logic        HOLDOVER_MODE,
	input wire logic        FREERUN_MODE,
	input wire logic        EXIT_ACTIVE,
	input wire logic [1:0]  LOOP_BW_SEL,
	input wire logic        HISTORY_GOOD,
	input wire logic [4:0]  HIST_LEN_CODE,
	input wire logic [4:0]  HIST_DELAY_CODE,
	input wire logic        RAMP_ACTIVE,
	input wire logic        RAMP_STEP,
	input wire logic [2:0]  RAMP_STEP_SIZE
);
	// --------
	// single clock domain
	// --------
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	// mode entry follows force and history
	AST_FORCE_HOLD:
		assert property (REG_WR && REG_ADDR == 16'h0535 && REG_WDATA[0] |-> ##[1:3] HOLD_STATUS)
		else $error("force write did not hold the loop");
	AST_MODE_EXCL:
		assert property (HOLD_STATUS == (HOLDOVER_MODE || FREERUN_MODE) && !(HOLDOVER_MODE && FREERUN_MODE))
		else $error("hold status disagrees with mode flags");
	AST_HOLD_HIST:
		assert property ($rose(HOLDOVER_MODE) |-> HISTORY_GOOD)
		else $error("holdover entered without good history");
	AST_FREE_HIST:
		assert property ($rose(FREERUN_MODE) |-> !HISTORY_GOOD)
		else $error("freerun entered with good history");

	// exit method and bandwidth
	AST_BW_NORMAL:
		assert property (!EXIT_ACTIVE && !$past(EXIT_ACTIVE) |-> LOOP_BW_SEL == 2'h2)
		else $error("bandwidth not normal outside exit");
	AST_RAMP_BW:
		assert property ($rose(RAMP_ACTIVE) |-> EXIT_ACTIVE && LOOP_BW_SEL == 2'h2)
		else $error("ramp exit changed bandwidth");
	AST_EXIT_DONE:
		assert property (EXIT_ACTIVE && RAMP_ACTIVE && RAMP_DONE |-> ##[1:2] !EXIT_ACTIVE)
		else $error("ramp done did not end exit");
	AST_STEP_PULSE:
		assert property (RAMP_STEP |-> RAMP_ACTIVE ##1 !RAMP_STEP)
		else $error("ramp step outside ramp or too long");

	// register copies
	AST_STEP_SIZE:
		assert property (REG_WR && REG_ADDR == 16'h05A6 |-> ##2 RAMP_STEP_SIZE == 3'($past(REG_WDATA, 2)))
		else $error("step size not taken");
	AST_HIST_LEN:
		assert property (REG_WR && REG_ADDR == 16'h052E |-> ##2 HIST_LEN_CODE == 5'($past(REG_WDATA, 2)))
		else $error("window length not taken");
	AST_HIST_DLY:
		assert property (REG_WR && REG_ADDR == 16'h052F |-> ##2 HIST_DELAY_CODE == 5'($past(REG_WDATA, 2)))
		else $error("ignore delay not taken");
endmodule

/* File: hoc_ctrl_tb.sv */
// self-checking bench for the holdover controller
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("unexpected %0t got %h want %h", $time, a, b); end end
`define WAIT_HI(c) begin k = 0; while ((c) !== 1'b1) begin tick(1); k++; if (k > 400) begin n_fail++; complete_run(); end end end

module hoc_ctrl_tb import hoc_pkg::*;;
	// --------
	// design ports and bench state
	// --------
	logic        CLK_SYS, RST_N, REG_WR, REG_RD, RAMP_DONE, LOCK_DONE;
	logic [15:0] REG_ADDR;
	logic [7:0]  REG_WDATA, REG_RDATA;
	logic [1:0]  SEL_PINS, ACTIVE_INPUT, LOOP_BW_SEL;
	logic [3:0]  CLK_VALID;
	logic        HOLD_STATUS, HOLDOVER_MODE, FREERUN_MODE, EXIT_ACTIVE, HIST_ACCUM;
	logic        HISTORY_GOOD, RAMP_ACTIVE, RAMP_STEP;
	logic [4:0]  HIST_LEN_CODE, HIST_DELAY_CODE;
	logic [2:0]  RAMP_STEP_SIZE;
	int          n_fail = 0;
	int          tests_run = 0;
	int          k;
	logic [1:0]  bw [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
	logic [15:0] ra [10] = '{16'h052A, 16'h0536, 16'h052E, 16'h052F, 16'h052C,
		16'h059B, 16'h05A6, 16'h0535, 16'h000E, 16'h0100};
	logic [7:0]  rv [10] = '{8'h00, 8'h00, 8'h0A, 8'h08, 8'h00, 8'h40, 8'h00, 8'h00,
		8'h20, 8'h00};

	// design with a short ramp base
	hoc_ctrl #(.RAMP_BASE_CYCLES(2)) i_hoc_ctrl (.CLK_SYS, .RST_N, .REG_ADDR, .REG_WDATA,
		.REG_WR, .REG_RD, .REG_RDATA, .SEL_PINS, .CLK_VALID, .RAMP_DONE, .LOCK_DONE,
		.ACTIVE_INPUT, .HOLD_STATUS, .HOLDOVER_MODE, .FREERUN_MODE, .EXIT_ACTIVE,
		.LOOP_BW_SEL, .HIST_ACCUM, .HISTORY_GOOD, .HIST_LEN_CODE, .HIST_DELAY_CODE,
		.RAMP_ACTIVE, .RAMP_STEP, .RAMP_STEP_SIZE);

	// 100 MHz clock
	initial begin
		CLK_SYS = 1'b0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end

	// --------
	// tasks
	// --------
	task automatic complete_run();
		$display("mismatches %0d of %0d", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge CLK_SYS);
	endtask
	task automatic rst();
		RST_N = 1'b0;
		tick(5);
		RST_N = 1'b1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		tick(1);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		tick(1);
		REG_WR = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		tick(1);
		REG_ADDR = a;
		REG_RD = 1'b1;
		tick(1);
		REG_RD = 1'b0;
		tick(1);
		`CHK(REG_RDATA, e)
	endtask
	// history qualification time from a fresh reset
	task automatic hist(input logic [4:0] l, input logic [4:0] d, input int e);
		CLK_VALID = 4'h0;
		rst();
		wr(16'h052E, {3'h0, l});
		wr(16'h052F, {3'h0, d});
		CLK_VALID = 4'hF;
		`WAIT_HI(HISTORY_GOOD)
		`CHK(k >= e && k <= e + 6, 1'b1)
		`CHK(HIST_ACCUM, 1'b1)
	endtask

	// --------
	// main sequence
	// --------
	initial begin
		{RST_N, REG_WR, REG_RD, RAMP_DONE, LOCK_DONE} = '0;
		{REG_ADDR, REG_WDATA, SEL_PINS, CLK_VALID} = '0;
		rst();
		wr(16'h0100, 8'hFF);
		wr(16'h000E, 8'h00);
		for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
		// input arrives then vanishes before history is good
		CLK_VALID = 4'hF;
		tick(10);
		`CHK(FREERUN_MODE, 1'b0)
		CLK_VALID = 4'h0;
		tick(3);
		`CHK(FREERUN_MODE, 1'b1)
		hist(5'h01, 5'h03, 80);
		hist(5'h02, 5'h01, 94);
		rd(16'h053F, 8'h02);
		// manual choice by pins, then by register
		SEL_PINS = 2'h2;
		tick(5);
		`CHK(ACTIVE_INPUT, 2'h2)
		wr(16'h052A, 8'h07);
		tick(2);
		`CHK(ACTIVE_INPUT, 2'h3)
		wr(16'h052A, 8'h0B);
		tick(2);
		`CHK(ACTIVE_INPUT, 2'h3)
		wr(16'h052A, 8'h03);
		tick(2);
		`CHK(ACTIVE_INPUT, 2'h1)
		// selected input fails, then returns through a ramp
		wr(16'h052C, 8'h20);
		wr(16'h05A6, 8'h05);
		`CHK(RAMP_STEP_SIZE, 3'h5)
		CLK_VALID = 4'hD;
		tick(3);
		`CHK(HOLDOVER_MODE, 1'b1)
		CLK_VALID = 4'hF;
		`WAIT_HI(RAMP_STEP)
		tick(1);
		`WAIT_HI(RAMP_STEP)
		`CHK(k, 3)
		`CHK(LOOP_BW_SEL, 2'h2)
		`CHK(RAMP_ACTIVE, 1'b1)
		RAMP_DONE = 1'b1;
		tick(1);
		RAMP_DONE = 1'b0;
		tick(2);
		`CHK(EXIT_ACTIVE, 1'b0)
		// forced hold with each bypassed exit bandwidth code
		for (int i = 0; i < 4; i++) begin
			wr(16'h052C, {3'h1, i[1], 1'b1, 3'h0});
			wr(16'h059B, {1'b0, i[0], 6'h0});
			wr(16'h0535, 8'h01);
			rd(16'h000E, 8'h20);
			`CHK(HOLDOVER_MODE, 1'b1)
			wr(16'h0535, 8'h00);
			tick(3);
			`CHK(LOOP_BW_SEL, bw[i])
			`CHK(RAMP_ACTIVE, 1'b0)
			LOCK_DONE = 1'b1;
			tick(1);
			LOCK_DONE = 1'b0;
			tick(2);
			`CHK(EXIT_ACTIVE, 1'b0)
		end
		// automatic revertive, then non-revertive, then reserved policy
		wr(16'h0536, 8'h02);
		tick(2);
		`CHK(ACTIVE_INPUT, 2'h0)
		CLK_VALID = 4'hE;
		tick(2);
		`CHK(ACTIVE_INPUT, 2'h1)
		CLK_VALID = 4'hF;
		tick(2);
		`CHK(ACTIVE_INPUT, 2'h0)
		wr(16'h0538, 8'h14);
		tick(2);
		`CHK(ACTIVE_INPUT, 2'h1)
		// policy first, so the better priority of input 0 must not pull the choice back
		wr(16'h0536, 8'h01);
		wr(16'h0538, 8'h21);
		tick(2);
		`CHK(ACTIVE_INPUT, 2'h1)
		CLK_VALID = 4'hD;
		tick(2);
		`CHK(ACTIVE_INPUT, 2'h0)
		CLK_VALID = 4'hF;
		tick(2);
		`CHK(ACTIVE_INPUT, 2'h0)
		// reserved policy keeps input 0, manual would have taken input 1
		wr(16'h0536, 8'h03);
		tick(2);
		`CHK(ACTIVE_INPUT, 2'h0)
		complete_run();
	end

	// cut a hung run short
	initial begin
		repeat (100000) @(posedge CLK_SYS);
		n_fail++;
		complete_run();
	end
endmodule

bind hoc_ctrl hoc_ctrl_assertions #(.RAMP_BASE_CYCLES(RAMP_BASE_CYCLES)) i_hoc_ctrl_assertions (
	.CLK_SYS, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .RAMP_DONE, .HOLD_STATUS,
	.HOLDOVER_MODE, .FREERUN_MODE, .EXIT_ACTIVE, .LOOP_BW_SEL, .HISTORY_GOOD,
	.HIST_LEN_CODE, .HIST_DELAY_CODE, .RAMP_ACTIVE, .RAMP_STEP, .RAMP_STEP_SIZE);
